// ### design/tid_map.vh
// Constants for the twelve-bit instruction decoder: field positions, opcodes, timing.
// Assumes inclusion by the decoder module only.
`ifndef TID_MAP_VH
`define TID_MAP_VH
// Instruction groups
`define TID_GRP_BYTE     2'h0
`define TID_GRP_BIT      2'h1
`define TID_GRP_LIT      2'h2
// Field positions
`define TID_F_HI         4
`define TID_D_BIT        5
`define TID_B_HI         7
`define TID_B_LO         5
`define TID_K8_HI        7
`define TID_K9_HI        8
`define TID_DIR_HI       2
`define TID_CTL_LO       3
// Encoding fields
`define TID_GRP_HI       11
`define TID_GRP_LO       10
`define TID_S_HI         9
`define TID_S_LO         6
`define TID_ENC_BYTE     2'h0
`define TID_ENC_BIT      2'h1
`define TID_ENC_PC       2'h2
`define TID_SUB_DECFSZ   4'hB
`define TID_SUB_INCFSZ   4'hF
`define TID_SUB_MISC     4'h0
`define TID_BOP_HI       9
`define TID_BOP_LO       8
`define TID_BOP_CLR      2'h0
`define TID_BOP_SET      2'h1
`define TID_BOP_TSTC     2'h2
`define TID_JMP_BIT      9
`define TID_CALL_BIT     8
`define TID_CODE_NOP     5'h00
`define TID_CTL_ZERO     2'h0
`define TID_DIR_MIN      3'h5
`define TID_SKIP_PHASE   2'h2
// Operation codes out
`define TID_OP_NOP       4'h0
`define TID_OP_ALU       4'h1
`define TID_OP_BCF       4'h2
`define TID_OP_BSF       4'h3
`define TID_OP_BTFSC     4'h4
`define TID_OP_BTFSS     4'h5
`define TID_OP_DECFSZ    4'h6
`define TID_OP_INCFSZ    4'h7
`define TID_OP_LITW      4'h8
`define TID_OP_CALL      4'h9
`define TID_OP_JUMP      4'hA
`define TID_OP_RETLW     4'hB
`define TID_OP_CTRL      4'hC
`define TID_OP_DIRLOAD   4'hD
// Special registers
`define TID_REG_TIMER0   5'h01
`define TID_REG_PORT     5'h06
`define TID_DIR_PORT     3'h6
// Last phase number of each four-phase instruction cycle
`define TID_PHASES       2'h3
`endif

// ### design/tid_decoder.v
// Twelve-bit instruction decoder and quarter-cycle sequencer.
// Assumes fetch supplies instr_i at each cycle start; datapath reports skip test result.
//
// Function
// - Accept each 12-bit word; split into opcode and operand fields.
// - Classify each instruction as byte, bit, or literal/control group.
// - Register-select field picks one of 32 file registers.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Bit-select field gives affected bit number in the 8-bit register.
// - Literal/control instructions yield an 8 or 9-bit constant.
// - One instruction cycle, two if skip taken or PC changes.
// - Each instruction cycle is four oscillator periods.
// - Don't-care bit positions never affect decoding.
// - PC writes other than unconditional jump force PC bit 8 low.
// - Direction load with operand 6 copies accumulator to port tristates.
// - I/O read-modify-write sources the pin levels, not the latch.
// - Writing timer-zero clears prescaler when assigned to it.
`timescale 1ns/1ps
`include "tid_map.vh"
module tid_decoder #(
   parameter IW = 12
) (
   // Clock and reset
   input  wire          clk_sys_i,
   input  wire          rst_i,
   // Fetch side
   input  wire [IW-1:0] instr_i,
   // Datapath feedback
   input  wire          skip_cond_i,
   input  wire          psa_timer_i,
   // Timing
   output reg           cyc_start_o,
   output reg  [1:0]    phase_o,
   output reg           cyc_second_o,
   // Decoded fields
   output reg  [1:0]    group_o,
   output reg  [3:0]    op_o,
   output reg  [3:0]    alu_fn_o,
   output reg  [4:0]    reg_sel_o,
   output reg           dest_file_o,
   output reg           dest_acc_o,
   output reg  [2:0]    bit_sel_o,
   output reg  [8:0]    literal_o,
   output reg           lit_wide_o,
   // Control effects
   output reg           pc_load_o,
   output reg           pc_bit8_clr_o,
   output reg           dir_load_o,
   output reg           src_pins_o,
   output reg           prescale_clr_o
);
   reg  [1:0] phase_ff;
   reg        skip_next_ff;
   reg  [1:0] nxt_group;
   reg  [3:0] nxt_op;
   reg        nxt_wr_f;
   reg        nxt_pc;
   wire       cyc_edge = (phase_ff == `TID_PHASES);
   wire       is_skip  = (op_o == `TID_OP_BTFSC) || (op_o == `TID_OP_BTFSS) ||
                         (op_o == `TID_OP_DECFSZ) || (op_o == `TID_OP_INCFSZ);
   // Slot after a taken skip or a program counter load is flushed
   wire       flush_next = skip_next_ff || (pc_load_o && !cyc_second_o);

   function is_io_reg;
      input [4:0] r;
      begin
         is_io_reg = (r == `TID_REG_PORT);
      end
   endfunction

   // Phase counter, four periods per cycle
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         phase_ff <= 2'h0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
      end
   end

   // Group and operation decode
   always @* begin
      nxt_group = `TID_GRP_LIT;
      nxt_op    = `TID_OP_NOP;
      nxt_wr_f  = 1'b0;
      nxt_pc    = 1'b0;
      case (instr_i[`TID_GRP_HI:`TID_GRP_LO])
         `TID_ENC_BYTE: begin
            nxt_group = `TID_GRP_BYTE;
            nxt_op    = `TID_OP_ALU;
            nxt_wr_f  = instr_i[`TID_D_BIT];
            case (instr_i[`TID_S_HI:`TID_S_LO])
               `TID_SUB_DECFSZ: begin
                  nxt_op = `TID_OP_DECFSZ;
               end
               `TID_SUB_INCFSZ: begin
                  nxt_op = `TID_OP_INCFSZ;
               end
               `TID_SUB_MISC: begin
                  if (!instr_i[`TID_D_BIT]) begin
                     nxt_group = `TID_GRP_LIT;
                     nxt_op    = `TID_OP_CTRL;
                     if (instr_i[`TID_F_HI:0] == `TID_CODE_NOP) begin
                        nxt_op = `TID_OP_NOP;
                     end else if (instr_i[`TID_F_HI:`TID_CTL_LO] == `TID_CTL_ZERO &&
                                  instr_i[`TID_DIR_HI:0] >= `TID_DIR_MIN) begin
                        nxt_op = `TID_OP_DIRLOAD;
                     end
                  end
               end
               default: begin
                  nxt_op = `TID_OP_ALU;
               end
            endcase
         end
         `TID_ENC_BIT: begin
            nxt_group = `TID_GRP_BIT;
            case (instr_i[`TID_BOP_HI:`TID_BOP_LO])
               `TID_BOP_CLR:  nxt_op = `TID_OP_BCF;
               `TID_BOP_SET:  nxt_op = `TID_OP_BSF;
               `TID_BOP_TSTC: nxt_op = `TID_OP_BTFSC;
               default:       nxt_op = `TID_OP_BTFSS;
            endcase
            nxt_wr_f = ~instr_i[`TID_BOP_HI];
         end
         `TID_ENC_PC: begin
            nxt_pc = 1'b1;
            if (instr_i[`TID_JMP_BIT]) begin
               nxt_op = `TID_OP_JUMP;
            end else if (instr_i[`TID_CALL_BIT]) begin
               nxt_op = `TID_OP_CALL;
            end else begin
               nxt_op = `TID_OP_RETLW;
            end
         end
         default: begin
            nxt_op = `TID_OP_LITW;
         end
      endcase
   end

   // Cycle timing and flush tracking
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         skip_next_ff <= 1'b0;
         cyc_start_o  <= 1'b0;
         phase_o      <= 2'h0;
         cyc_second_o <= 1'b0;
      end else begin
         phase_o     <= phase_ff + 2'h1;
         cyc_start_o <= cyc_edge;
         // Skip outcome sampled in the third phase of the cycle
         if (phase_ff == `TID_SKIP_PHASE && is_skip && !cyc_second_o) begin
            skip_next_ff <= skip_cond_i;
         end
         if (cyc_edge) begin
            cyc_second_o <= flush_next;
            skip_next_ff <= 1'b0;
         end
      end
   end

   // Decoded fields, loaded once per instruction cycle
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         group_o        <= `TID_GRP_LIT;
         op_o           <= `TID_OP_NOP;
         alu_fn_o       <= 4'h0;
         reg_sel_o      <= 5'h00;
         dest_file_o    <= 1'b0;
         dest_acc_o     <= 1'b0;
         bit_sel_o      <= 3'h0;
         literal_o      <= 9'h000;
         lit_wide_o     <= 1'b0;
         pc_load_o      <= 1'b0;
         pc_bit8_clr_o  <= 1'b0;
         dir_load_o     <= 1'b0;
         src_pins_o     <= 1'b0;
         prescale_clr_o <= 1'b0;
      end else begin
         if (cyc_edge) begin
            if (flush_next) begin
               // Flush slot runs as no-operation
               group_o        <= `TID_GRP_LIT;
               op_o           <= `TID_OP_NOP;
               dest_file_o    <= 1'b0;
               dest_acc_o     <= 1'b0;
               pc_load_o      <= 1'b0;
               pc_bit8_clr_o  <= 1'b0;
               dir_load_o     <= 1'b0;
               src_pins_o     <= 1'b0;
               prescale_clr_o <= 1'b0;
            end else begin
               group_o     <= nxt_group;
               op_o        <= nxt_op;
               alu_fn_o    <= instr_i[`TID_S_HI:`TID_S_LO];
               reg_sel_o   <= instr_i[`TID_F_HI:0];
               dest_file_o <= nxt_wr_f && nxt_group != `TID_GRP_LIT;
               dest_acc_o  <= nxt_group == `TID_GRP_BYTE && !instr_i[`TID_D_BIT];
               bit_sel_o   <= instr_i[`TID_B_HI:`TID_B_LO];
               // Upper literal bit only for jump; others zero-fill (no don't-care leak)
               literal_o   <= (nxt_op == `TID_OP_JUMP) ? instr_i[`TID_K9_HI:0] :
                              {1'b0, instr_i[`TID_K8_HI:0]};
               lit_wide_o  <= (nxt_op == `TID_OP_JUMP);
               pc_load_o   <= nxt_pc;
               pc_bit8_clr_o <= nxt_pc && nxt_op != `TID_OP_JUMP;
               dir_load_o  <= nxt_op == `TID_OP_DIRLOAD &&
                              instr_i[`TID_DIR_HI:0] == `TID_DIR_PORT;
               src_pins_o  <= nxt_group != `TID_GRP_LIT &&
                              is_io_reg(instr_i[`TID_F_HI:0]);
               prescale_clr_o <= psa_timer_i && nxt_wr_f &&
                                 nxt_group != `TID_GRP_LIT &&
                                 instr_i[`TID_F_HI:0] == `TID_REG_TIMER0;
            end
         end
      end
   end
endmodule

// ### tb/tid_checker.sv
// Checker for the instruction decoder outputs.
// Assumes binding to tid_decoder; sees its ports only.
`timescale 1ns/1ps
module tid_checker (
   input logic        clk_sys_i,
   input logic        rst_i,
   input logic [11:0] instr_i,
   input logic        skip_cond_i,
   input logic        cyc_start_o,
   input logic [1:0]  phase_o,
   input logic        cyc_second_o,
   input logic [1:0]  group_o,
   input logic [3:0]  op_o,
   input logic [4:0]  reg_sel_o,
   input logic        dest_file_o,
   input logic [2:0]  bit_sel_o,
   input logic [8:0]  literal_o,
   input logic        pc_load_o,
   input logic        pc_bit8_clr_o,
   input logic        dir_load_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   wire t3 = (phase_o == 2'h3);
   a_phase_wrap: assert property (t3 |=> phase_o == 2'h0 && cyc_start_o)
      else $error("phase wrap wrong");
   a_cyc_four: assert property (cyc_start_o |=> !cyc_start_o [*3] ##1 cyc_start_o)
      else $error("cycle not four clocks");
   a_out_hold: assert property (!cyc_start_o |-> $stable(op_o) && $stable(literal_o))
      else $error("outputs moved mid cycle");
   a_bit_fields: assert property (t3 && instr_i[11:10] == 2'h1 |=> cyc_second_o
      || (group_o == 2'h1 && reg_sel_o == $past(instr_i[4:0])
      && bit_sel_o == $past(instr_i[7:5]))) else $error("bit fields wrong");
   a_dest_sel: assert property (t3 && instr_i[11:10] == 2'h0 && instr_i[9:6] != 4'h0
      |=> cyc_second_o || dest_file_o == $past(instr_i[5])) else $error("dest wrong");
   a_jump_lit: assert property (t3 && instr_i[11:9] == 3'h5 |=> cyc_second_o
      || (literal_o == $past(instr_i[8:0]) && pc_load_o && !pc_bit8_clr_o))
      else $error("jump decode wrong");
   a_call_clr: assert property (t3 && instr_i[11:8] == 4'h9 |=> cyc_second_o
      || (pc_bit8_clr_o && literal_o == {1'b0, $past(instr_i[7:0])}))
      else $error("call decode wrong");
   a_pc_flush: assert property (cyc_start_o && pc_load_o |-> ##4 cyc_second_o && op_o == 4'h0)
      else $error("no flush after pc load");
   a_skip_flush: assert property (phase_o == 2'h2 && skip_cond_i && !cyc_second_o
      && op_o inside {[4'h4:4'h7]} |-> ##2 cyc_second_o) else $error("no flush after skip");
   a_dir_load: assert property (t3 && instr_i == 12'h006 |=> cyc_second_o || dir_load_o)
      else $error("direction load missing");
   c_pc_load: cover property (cyc_start_o && pc_load_o);
   c_flush: cover property (cyc_second_o);
   c_dir: cover property (dir_load_o);
endmodule

// ### tb/testbench.sv
// Self-checking bench for the instruction decoder.
// Assumes tid_decoder and tid_checker are compiled first.
`timescale 1ns/1ps
module testbench;
   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [11:0] instr_i = 12'h000;
   logic        skip_cond_i = 1'b0;
   logic        psa_timer_i = 1'b0;
   wire  [1:0]  phase_o, group_o;
   wire  [3:0]  op_o, alu_fn_o;
   wire  [4:0]  reg_sel_o;
   wire  [2:0]  bit_sel_o;
   wire  [8:0]  literal_o;
   wire         cyc_start_o, cyc_second_o, dest_file_o, dest_acc_o, lit_wide_o;
   wire         pc_load_o, pc_bit8_clr_o, dir_load_o, src_pins_o, prescale_clr_o;
   int          err_total = 0;
   int          checks = 0;
   tid_decoder DUT (.*);
   always #10 clk_sys_i = ~clk_sys_i;
   task end_sim;
      if (err_total == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string n, input logic [11:0] e, input logic [11:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask
   // Word is taken at the phase 3 edge, result read in phase 0
   task issue(input logic [11:0] w);
      do @(negedge clk_sys_i); while (phase_o !== 2'h2);
      @(posedge clk_sys_i);
      instr_i <= w;
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
   endtask
   task t_byte;
      for (int i = 0; i < 4; i++) begin
         issue({6'h07, i[0], {5{i[1]}}});
         chk("group", 12'h000, group_o);
         chk("alu_fn", 12'h007, alu_fn_o);
         chk("reg_sel", {7'h00, {5{i[1]}}}, reg_sel_o);
         chk("dest_file", i[0], dest_file_o);
         chk("dest_acc", !i[0], dest_acc_o);
      end
   endtask
   task t_bit_lit;
      issue(12'h5E6);
      chk("group", 12'h001, group_o);
      chk("bit_sel", 12'h007, bit_sel_o);
      chk("src_pins", 12'h001, src_pins_o);
      issue(12'hCA5);
      chk("group", 12'h002, group_o);
      chk("literal", 12'h0A5, literal_o);
      chk("lit_wide", 12'h000, lit_wide_o);
   endtask
   task t_pc;
      issue(12'hBFF);
      chk("literal", 12'h1FF, literal_o);
      chk("pc_load", 12'h001, pc_load_o);
      chk("bit8_clr", 12'h000, pc_bit8_clr_o);
      issue(12'h1E5);
      chk("second", 12'h001, cyc_second_o);
      chk("op", 12'h000, op_o);
      issue(12'h9AB);
      chk("bit8_clr", 12'h001, pc_bit8_clr_o);
      issue(12'h000);
   endtask
   task t_skip;
      logic [11:0] w [4];
      w = '{12'h6E5, 12'h7E5, 12'h2E5, 12'h3E5};
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys_i);
         skip_cond_i <= i[0];
         issue(w[i / 2]);
         issue(12'h1E5);
         chk("second", i[0], cyc_second_o);
      end
   endtask
   task t_dir;
      issue(12'h006);
      chk("dir_load", 12'h001, dir_load_o);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys_i);
         psa_timer_i <= i[0];
         issue(12'h021);
         chk("prescale", i[0], prescale_clr_o);
      end
   endtask
   initial begin
      repeat (16) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      t_byte;
      t_bit_lit;
      t_pc;
      t_skip;
      t_dir;
      end_sim;
   end
   initial begin
      #200000;
      err_total++;
      end_sim;
   end
endmodule
bind tid_decoder tid_checker u_chk (.*);
